/* File: verilog/swe_core.sv */
// Purpose: wake source arming, detection and suspend control with an axi4-lite register slave
// Assumes: all inputs synchronous to aclk; one write and one read in flight
// Notes: top module; every output comes from a flip-flop
//
// Summary of operation
// - per-pin wake enable and polarity
// - pin wakes work in every suspend mode
// - suspend needs mode write then bus suspend
// - wake returns normal, remote wake or U0
// - wake source keeps pin and network bits
// - address match and broadcast each enabled
// - set mac status wakes at once
// - mac status holds while mac event
// - network wakes only in modes 0, 3
// - phy status wakes, holds while interrupt
// - link wake only in modes 0, 1
// - good frame wake with filter enable
// - later frames stored; wake frame optional
// - good-frame wake needs mode 3
// - wake frame flagged in its status
// - later frames must pass filters, fcs
// - pass control bypasses filter for wake
// - pin wake sets interrupt status bit
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
`include "swe_cfg.svh"
module swe_core import swe_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [7:0] pins,
   input wire logic mac_evt,
   input wire logic phy_int,
   input wire logic usb_suspend,
   input wire logic usb_ss,
   input wire logic rx_done,
   input wire logic rx_good,
   input wire logic rx_filt_pass,
   input wire logic rx_pattern,
   input wire logic rx_da_match,
   input wire logic rx_bcast,
   output logic suspended,
   output logic remote_wake,
   output logic u0_req,
   output logic func_wake,
   output logic frame_store,
   output logic frame_wake_flag
);
   swe_core_t s;      // present state
   swe_core_t next_s; // next state
   logic allow_net;   // network sources permitted in the selected mode
   logic allow_link;  // link change permitted
   logic allow_good;  // good frame permitted
   logic wake_cond;   // some enabled, permitted source is pending
   logic wr_go;       // address and data both held
   logic [31:0] wm;   // write data cut by strobes
   logic [31:0] pmt_rd; // power control readback
   logic [31:0] mrg;  // merged write value
   logic [31:0] rd;   // read mux
   swe_evt_if ev();

   // byte strobes to a bit mask
   function automatic logic [31:0] swe_mask(input logic [3:0] strb);
      logic [31:0] m;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   // a decoded register lives at this byte address
   function automatic logic swe_mapped(input logic [11:0] a);
      case (a)
         `SWE_A_INT, `SWE_A_PMT, `SWE_A_CFG0, `SWE_A_CFG1: return 1'b1;
         `SWE_A_PWAKE, `SWE_A_WSRC, `SWE_A_WCS1, `SWE_A_RFC: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // pin detector
   swe_pin_wake #(.NPIN(8)) u_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pins(pins),
      .ev(ev.pin)
   );

   // frame matching and fifo store decision
   swe_frame_gate u_frm (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .rx_done(rx_done),
      .rx_good(rx_good),
      .rx_filt_pass(rx_filt_pass),
      .rx_pattern(rx_pattern),
      .rx_da_match(rx_da_match),
      .rx_bcast(rx_bcast),
      .ev(ev.frm)
   );

   // settings handed to the detectors
   assign ev.io_en = s.io_en;
   assign ev.wake_en = s.wake_en;
   assign ev.pol = s.pol;
   assign ev.suspended = (s.st == SWE_SUSP);
   assign ev.arm = (s.st == SWE_NORMAL) && s.susp_req;
   assign ev.allow_net = allow_net;
   assign ev.allow_good = allow_good;
   assign ev.net_en = s.net_en;
   assign ev.filt_en = s.wcs[`SWE_WC_FILT];
   assign ev.addr_en = s.wcs[`SWE_WC_ADDR];
   assign ev.bc_en = s.wcs[`SWE_WC_BC];
   assign ev.store_wake = s.wcs[`SWE_WC_STORE];
   assign ev.always_pass_wake_frame = s.always_pass_wake_frame;

   // which sources each suspend mode listens to
   always_comb begin
      allow_net = (s.mode == 2'h0) || (s.mode == 2'h3);
      allow_link = (s.mode == 2'h0) || (s.mode == 2'h1);
      allow_good = (s.mode == 2'h3);
      // pins are honoured whatever the mode; a leftover pin flag re-wakes at once
      wake_cond = (|s.int_pin)
         | (s.wake_status_bits[1] & s.net_en & allow_net)
         | (s.wake_status_bits[0] & s.link_en & allow_link)
         | (s.wake_status_bits[1] & s.wcs[`SWE_WC_FILT] & ~s.net_en & allow_good);
   end

   // write helpers
   always_comb begin
      wr_go = s.awh & s.wh & ~s.bvalid;
      wm = s.wdata & swe_mask(s.wstrb);
      pmt_rd = '0;
      pmt_rd[`SWE_PMT_MODE +: 2] = s.mode;
      pmt_rd[`SWE_PMT_NET] = s.net_en;
      pmt_rd[`SWE_PMT_LINK] = s.link_en;
      pmt_rd[`SWE_PMT_WAKE_STATUS_BITS +: 2] = s.wake_status_bits;
      pmt_rd[`SWE_PMT_SUSP] = (s.st == SWE_SUSP);
   end

   // read mux; unmapped words read zero
   always_comb begin
      rd = '0;
      case (araddr)
         `SWE_A_INT: rd[7:0] = s.int_pin;
         `SWE_A_PMT: rd = pmt_rd;
         `SWE_A_CFG0: rd[3:0] = s.io_en[3:0];
         `SWE_A_CFG1: rd[3:0] = s.io_en[7:4];
         `SWE_A_PWAKE: rd[15:0] = {s.pol, s.wake_en};
         `SWE_A_WSRC: rd[12:0] = s.wsrc;
         `SWE_A_WCS1: rd[3:0] = s.wcs;
         `SWE_A_RFC: rd[`SWE_RF_PASS] = s.always_pass_wake_frame;
         default: rd = '0;
      endcase
   end

   // whole next-state function
   always_comb begin
      next_s = s;
      mrg = '0;
      next_s.remote_wake = 1'b0;
      next_s.u0_req = 1'b0;
      next_s.func_wake = 1'b0;
      // capture address and data in either order
      if (awvalid && s.awready) begin
         next_s.awh = 1'b1;
         next_s.awaddr = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.wh = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      // register write: status bits clear by writing one, before the sets below
      if (wr_go) begin
         next_s.awh = 1'b0;
         next_s.wh = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = swe_mapped(s.awaddr) ? `SWE_OKAY : `SWE_DECERR;
         case (s.awaddr)
            `SWE_A_INT: next_s.int_pin = s.int_pin & ~wm[7:0];
            `SWE_A_PMT: begin
               mrg = (pmt_rd & ~swe_mask(s.wstrb)) | wm;
               next_s.mode = mrg[`SWE_PMT_MODE +: 2];
               next_s.net_en = mrg[`SWE_PMT_NET];
               next_s.link_en = mrg[`SWE_PMT_LINK];
               next_s.wake_status_bits = s.wake_status_bits & ~wm[`SWE_PMT_WAKE_STATUS_BITS +: 2];
               next_s.susp_req = s.wstrb[0];
            end
            `SWE_A_CFG0: begin
               mrg = ({28'h0, s.io_en[3:0]} & ~swe_mask(s.wstrb)) | wm;
               next_s.io_en[3:0] = mrg[3:0];
            end
            `SWE_A_CFG1: begin
               mrg = ({28'h0, s.io_en[7:4]} & ~swe_mask(s.wstrb)) | wm;
               next_s.io_en[7:4] = mrg[3:0];
            end
            `SWE_A_PWAKE: begin
               mrg = ({16'h0, s.pol, s.wake_en} & ~swe_mask(s.wstrb)) | wm;
               next_s.wake_en = mrg[`SWE_PW_EN +: 8];
               next_s.pol = mrg[`SWE_PW_POL +: 8];
            end
            `SWE_A_WSRC: next_s.wsrc = s.wsrc & ~wm[12:0];
            `SWE_A_WCS1: begin
               mrg = ({28'h0, s.wcs} & ~swe_mask(s.wstrb)) | wm;
               next_s.wcs = mrg[3:0];
            end
            `SWE_A_RFC: begin
               mrg = ({31'h0, s.always_pass_wake_frame} & ~swe_mask(s.wstrb)) | wm;
               next_s.always_pass_wake_frame = mrg[`SWE_RF_PASS];
            end
            default: ;
         endcase
      end
      next_s.awready = ~next_s.awh & ~next_s.bvalid;
      next_s.wready = ~next_s.wh & ~next_s.bvalid;
      // register read, answered one edge after it is taken
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd;
         next_s.rresp = swe_mapped(araddr) ? `SWE_OKAY : `SWE_DECERR;
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      next_s.arready = ~next_s.rvalid;
      // hardware sets come last so an event beats a clear in the same cycle
      next_s.int_pin = next_s.int_pin | ev.pin_hit;
      next_s.wsrc[7:0] = next_s.wsrc[7:0] | ev.pin_hit;
      next_s.wake_status_bits[1] = next_s.wake_status_bits[1] | mac_evt | ev.mac_hit | ev.good_hit;
      next_s.wake_status_bits[0] = next_s.wake_status_bits[0] | phy_int;
      // record the causes while suspended
      if (s.st == SWE_SUSP) begin
         next_s.wsrc[`SWE_WS_MAC] = next_s.wsrc[`SWE_WS_MAC] | (s.wake_status_bits[1] & s.net_en & allow_net);
         next_s.wsrc[`SWE_WS_PHY] = next_s.wsrc[`SWE_WS_PHY] | (s.wake_status_bits[0] & s.link_en & allow_link);
         next_s.wsrc[`SWE_WS_GOOD] = next_s.wsrc[`SWE_WS_GOOD] | ev.good_hit;
         next_s.wsrc[`SWE_WS_ADDR] = next_s.wsrc[`SWE_WS_ADDR] | (ev.addr_hit & s.net_en & allow_net);
         next_s.wsrc[`SWE_WS_BC] = next_s.wsrc[`SWE_WS_BC] | (ev.bc_hit & s.net_en & allow_net);
      end
      // suspend sequencing
      case (s.st)
         SWE_NORMAL: begin
            if (s.susp_req) begin
               next_s.st = SWE_ARMED;
            end
         end
         SWE_ARMED: begin
            // the mode is written; wait for the host to suspend the bus or link
            if (usb_suspend) begin
               next_s.st = SWE_SUSP;
            end
         end
         SWE_SUSP: begin
            if (wake_cond) begin
               // back to normal and tell the host in the way the link speed asks for
               next_s.st = SWE_NORMAL;
               next_s.susp_req = 1'b0;
               next_s.remote_wake = ~usb_ss;
               next_s.u0_req = usb_ss;
               next_s.func_wake = usb_ss;
            end else if (!usb_suspend) begin
               // host resumed on its own
               next_s.st = SWE_NORMAL;
               next_s.susp_req = 1'b0;
            end
         end
         default: next_s.st = SWE_NORMAL;
      endcase
   end

   // register the state; clock enable freezes everything
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // outputs straight from state
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign suspended = (s.st == SWE_SUSP);
   assign remote_wake = s.remote_wake;
   assign u0_req = s.u0_req;
   assign func_wake = s.func_wake;
   assign frame_store = ev.store;
   assign frame_wake_flag = ev.flag;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // wake from suspend with an enabled cause
   sequence swe_woken;
      ce && s.st == SWE_SUSP && wake_cond;
   endsequence
   sequence swe_signalled;
      s.st == SWE_NORMAL && (s.remote_wake ^ (s.u0_req && s.func_wake));
   endsequence
   chk_wake_exit_signal: assert property (swe_woken |=> swe_signalled)
      else $error("wake did not return to normal with notification");
   chk_suspend_needs_req: assert property (ce && s.st != SWE_SUSP && s.st != SWE_ARMED |=> s.st != SWE_SUSP)
      else $error("suspend entered without a mode write");
   chk_mac_status_held: assert property (ce && mac_evt |=> s.wake_status_bits[1])
      else $error("mac wake status cleared while event active");
   chk_phy_status_held: assert property (ce && phy_int |=> s.wake_status_bits[0])
      else $error("phy wake status cleared while interrupt active");
   chk_net_immediate: assert property (ce && s.st == SWE_SUSP && s.wake_status_bits[1] && s.net_en && allow_net |=> s.st == SWE_NORMAL)
      else $error("pending mac status did not wake");
   chk_idle_stays_suspended: assert property (ce && s.st == SWE_SUSP && !wake_cond && usb_suspend |=> s.st == SWE_SUSP)
      else $error("woke without an enabled permitted source");
   chk_pin_int_latch: assert property (ce && ev.pin_hit != 8'h0 |=> (s.int_pin & $past(ev.pin_hit)) == $past(ev.pin_hit))
      else $error("pin wake did not set interrupt status");
   chk_wsrc_pin_record: assert property (ce && ev.pin_hit != 8'h0 |=>
      (s.wsrc[7:0] & $past(ev.pin_hit)) == $past(ev.pin_hit))
      else $error("pin source bit not recorded");
endmodule // swe_core
`default_nettype wire

/* File: verilog/swe_cfg.svh */
// Purpose: register offsets, field positions and response codes of the wake control block
// Assumes: 32-bit register words on a 12-bit byte address
// Notes: definitions only
`ifndef SWE_CFG_SVH
`define SWE_CFG_SVH
// register byte addresses
`define SWE_A_INT 12'h00c
`define SWE_A_PMT 12'h014
`define SWE_A_CFG0 12'h018
`define SWE_A_CFG1 12'h01c
`define SWE_A_PWAKE 12'h020
`define SWE_A_WSRC 12'h024
`define SWE_A_WCS1 12'h028
`define SWE_A_RFC 12'h02c
// power management control fields
`define SWE_PMT_MODE 0
`define SWE_PMT_NET 2
`define SWE_PMT_LINK 3
`define SWE_PMT_WAKE_STATUS_BITS 4
`define SWE_PMT_SUSP 8
// pin wake register: enables low byte, polarity next byte
`define SWE_PW_EN 0
`define SWE_PW_POL 8
// wake source bits above the pin flags
`define SWE_WS_MAC 8
`define SWE_WS_PHY 9
`define SWE_WS_GOOD 10
`define SWE_WS_ADDR 11
`define SWE_WS_BC 12
// wake control status 1 bits
`define SWE_WC_ADDR 0
`define SWE_WC_BC 1
`define SWE_WC_FILT 2
`define SWE_WC_STORE 3
// receive filter control bit
`define SWE_RF_PASS 0
// answers
`define SWE_OKAY 2'h0
`define SWE_DECERR 2'h3
`endif

/* File: verilog/swe_pkg.sv */
// Purpose: shared types of the wake control block
// Assumes: nothing
// Notes: the core state is one packed struct
`default_nettype none
package swe_pkg;
   // power state of the function
   typedef enum logic [1:0] {SWE_NORMAL, SWE_ARMED, SWE_SUSP} swe_st_t;
   // whole core state
   typedef struct packed {
      swe_st_t st;
      logic [1:0] mode;
      logic susp_req;
      logic net_en;
      logic link_en;
      logic [1:0] wake_status_bits;
      logic [7:0] io_en;
      logic [7:0] wake_en;
      logic [7:0] pol;
      logic [7:0] int_pin;
      logic [12:0] wsrc;
      logic [3:0] wcs;
      logic always_pass_wake_frame;
      logic awh;
      logic [11:0] awaddr;
      logic wh;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic remote_wake;
      logic u0_req;
      logic func_wake;
   } swe_core_t;
   // frame gate state
   typedef struct packed {
      logic post_wake;
      logic mac_hit;
      logic good_hit;
      logic addr_hit;
      logic bc_hit;
      logic store;
      logic flag;
   } swe_frm_t;
endpackage
`default_nettype wire

/* File: verilog/swe_evt_if.sv */
// Purpose: carries settings and detected events between the core and its detectors
// Assumes: single clock domain
// Notes: all outputs of each party come from its flip-flops
`default_nettype none
interface swe_evt_if;
   logic [7:0] io_en;   // pin usable as input
   logic [7:0] wake_en; // pin armed for wake
   logic [7:0] pol;     // active level per pin
   logic [7:0] pin_hit; // pin at its active level
   logic suspended;     // function in suspend
   logic arm;           // new suspend request written
   logic allow_net;     // network events permitted in mode
   logic allow_good;    // good-frame events permitted in mode
   logic net_en;
   logic filt_en;
   logic addr_en;
   logic bc_en;
   logic store_wake;
   logic always_pass_wake_frame;
   logic mac_hit;       // network wake frame seen
   logic good_hit;      // good frame caused a wake
   logic addr_hit;
   logic bc_hit;
   logic store;         // write frame into receive fifo
   logic flag;          // frame is the wake frame
   modport core(output io_en, wake_en, pol, suspended, arm, allow_net, allow_good, net_en, filt_en,
                output addr_en, bc_en, store_wake, always_pass_wake_frame,
                input pin_hit, mac_hit, good_hit, addr_hit, bc_hit, store, flag);
   modport pin(input io_en, wake_en, pol, output pin_hit);
   modport frm(input suspended, arm, allow_net, allow_good, net_en, filt_en, addr_en, bc_en,
               input store_wake, always_pass_wake_frame, output mac_hit, good_hit, addr_hit, bc_hit, store, flag);
endinterface
`default_nettype wire

/* File: verilog/swe_pin_wake.sv */
// Purpose: per-pin wake detection
// Assumes: pins synchronous to aclk
// Notes: one cycle of registering between pin and hit
`default_nettype none
module swe_pin_wake #(parameter int NPIN = 8) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [NPIN-1:0] pins,
   swe_evt_if.pin ev
);
   logic [NPIN-1:0] s;      // registered hits
   logic [NPIN-1:0] next_s; // raw hits
   // a pin counts only when usable, armed and at its chosen level
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      always_comb begin
         next_s[i] = ev.io_en[i] & ev.wake_en[i] & (pins[i] == ev.pol[i]);
      end
   end
   // register the hits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end
   assign ev.pin_hit = s;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_pin_unarmed_quiet: assert property (ce |=> (s & ~$past(ev.wake_en & ev.io_en)) == '0)
      else $error("unarmed pin reported a wake");
   chk_pin_level_seen: assert property (ce |=> s == $past(ev.io_en & ev.wake_en & ~(pins ^ ev.pol)))
      else $error("armed pin at active level missed");
endmodule // swe_pin_wake
`default_nettype wire

/* File: verilog/swe_frame_gate.sv */
// Purpose: frame wake matching and receive fifo store decision
// Assumes: one frame end pulse per received frame with its attributes
// Notes: store and flag are one-cycle pulses one edge after the frame end
`default_nettype none
module swe_frame_gate import swe_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic rx_done,
   input wire logic rx_good,
   input wire logic rx_filt_pass,
   input wire logic rx_pattern,
   input wire logic rx_da_match,
   input wire logic rx_bcast,
   swe_evt_if.frm ev
);
   swe_frm_t s;      // present state
   swe_frm_t next_s; // next state
   logic ok;         // frame ended without corruption
   logic net_trig;   // frame wakes through the network path
   // classify each finished frame
   always_comb begin
      next_s = s;
      ok = rx_done & rx_good;
      next_s.addr_hit = ok & rx_da_match & ev.addr_en;
      next_s.bc_hit = ok & rx_bcast & ev.bc_en;
      next_s.mac_hit = ok & rx_pattern | next_s.addr_hit | next_s.bc_hit;
      net_trig = next_s.mac_hit & ev.net_en & ev.allow_net & ev.suspended;
      next_s.good_hit = ok & rx_filt_pass & ev.filt_en & ~ev.net_en & ev.allow_good & ev.suspended;
      next_s.flag = 1'b0;
      if (net_trig | next_s.good_hit) begin
         // the wake frame may skip the filter, and is kept only on request
         next_s.store = ev.store_wake & (ev.always_pass_wake_frame | rx_filt_pass);
         next_s.flag = next_s.store;
         next_s.post_wake = 1'b1;
      end else if (!ev.suspended || s.post_wake) begin
         next_s.store = ok & rx_filt_pass;
      end else begin
         next_s.store = 1'b0;
      end
      if (ev.arm) begin
         next_s.post_wake = 1'b0;
      end
   end
   // register the state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end
   assign ev.mac_hit = s.mac_hit;
   assign ev.good_hit = s.good_hit;
   assign ev.addr_hit = s.addr_hit;
   assign ev.bc_hit = s.bc_hit;
   assign ev.store = s.store;
   assign ev.flag = s.flag;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_store_needs_good: assert property (ce |=> !s.store || $past(rx_done && rx_good))
      else $error("corrupt frame stored");
   chk_flag_with_store: assert property (s.flag |-> s.store && $past(ev.suspended))
      else $error("wake flag outside a stored wake frame");
endmodule // swe_frame_gate
`default_nettype wire

/* File: sim/swe_host_model.sv */
// Purpose: host end of the usb link; suspends on request and counts wake signaling
// Assumes: aclk domain; wake pulses are one cycle wide
// Notes: resumes as soon as the function signals a wake
`default_nettype none
module swe_host_model (
   input wire logic aclk,
   input wire logic go,
   input wire logic usb_ss,
   input wire logic remote_wake,
   input wire logic u0_req,
   input wire logic func_wake,
   output logic usb_suspend,
   output logic [7:0] n_hs,
   output logic [7:0] n_ss
);
   timeunit 1ns;
   timeprecision 1ns;
   logic go_q; // last request level, to find its rise
   initial begin
      usb_suspend = 1'b0;
      n_hs = 8'h00;
      n_ss = 8'h00;
      go_q = 1'b0;
   end
   // remote wake is taken as already enabled by the host
   always @(posedge aclk) begin
      go_q <= go;
      if (!go || remote_wake || u0_req) begin
         usb_suspend <= 1'b0;
      end else if (!go_q) begin
         usb_suspend <= 1'b1;
      end
      // only the wake kind that suits the link speed is counted
      if (remote_wake && !usb_ss) begin
         n_hs <= n_hs + 8'h01;
      end
      if (u0_req && func_wake && usb_ss) begin
         n_ss <= n_ss + 8'h01;
      end
   end
endmodule // swe_host_model
`default_nettype wire

/* File: sim/swe_core_tb.sv */
// Purpose: self-checking bench of the wake control block
// Assumes: host model drives the usb suspend line
// Notes: one task per scenario; rx_pattern, rx_da_match stay low
`default_nettype none
module swe_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, go;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   logic [7:0] pins, n_hs, n_ss;
   logic mac_evt, phy_int, usb_ss, usb_suspend, rx_done, rx_good, rx_filt_pass, rx_pattern, rx_da_match, rx_bcast;
   logic awready, wready, bvalid, arready, rvalid, suspended, remote_wake, u0_req, func_wake;
   logic frame_store, frame_wake_flag;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   swe_core i_dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
      .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .pins,
      .mac_evt, .phy_int, .usb_suspend, .usb_ss, .rx_done, .rx_good, .rx_filt_pass, .rx_pattern,
      .rx_da_match, .rx_bcast, .suspended, .remote_wake, .u0_req, .func_wake, .frame_store, .frame_wake_flag);
   swe_host_model i_host (.aclk, .go, .usb_ss, .remote_wake, .u0_req, .func_wake, .usb_suspend, .n_hs, .n_ss);
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // hang guard, far above the 140 or so cycles the tests need
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
         begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
      join
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      rr = bresp;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      rr = rresp;
      chk(rdata, exp);
   endtask
   task automatic sus(input logic [31:0] w);
      wr(12'h014, w);
      go <= 1'b1;
      do @(posedge aclk); while (!suspended);
   endtask
   // wait for resume, then compare the host's wake tallies
   task automatic wake(input logic [7:0] hs, input logic [7:0] ss);
      do @(posedge aclk); while (suspended);
      @(posedge aclk);
      chk({16'h0, n_hs, n_ss}, {16'h0, hs, ss});
      go <= 1'b0;
   endtask
   // one frame end with attributes good, filter pass, broadcast; expects store and flag
   task automatic frm(input logic [2:0] f, input logic [1:0] e);
      @(posedge aclk);
      {rx_good, rx_filt_pass, rx_bcast} <= f;
      rx_done <= 1'b1;
      @(posedge aclk);
      rx_done <= 1'b0;
      @(posedge aclk);
      chk({30'h0, frame_store, frame_wake_flag}, {30'h0, e});
   endtask
   task automatic t_pin();
      wr(12'h01c, 32'h2);
      wr(12'h020, 32'h20);
      sus(32'h2);
      pins <= 8'hdf;
      wake(8'h1, 8'h0);
      pins <= 8'hff;
      rd(12'h024, 32'h20);
      rd(12'h00c, 32'h20);
      wr(12'h00c, 32'h20);
      rd(12'h00c, 32'h0);
      wr(12'h024, 32'h20);
      rd(12'h024, 32'h0);
      rd(12'h100, 32'h0);
      chk({30'h0, rr}, 32'h3);
      wr(12'h100, 32'h0);
      chk({30'h0, rr}, 32'h3);
      $display("pin wake test done");
   endtask
   task automatic t_net();
      usb_ss <= 1'b1;
      sus(32'h5);
      mac_evt <= 1'b1; // pattern filters taken as programmed
      repeat (6) @(posedge aclk);
      chk({31'h0, suspended}, 32'h1);
      go <= 1'b0;
      wr(12'h014, 32'h27);
      rd(12'h014, 32'h27);
      sus(32'h7);
      wake(8'h1, 8'h1);
      mac_evt <= 1'b0;
      rd(12'h024, 32'h100);
      wr(12'h024, 32'h100);
      wr(12'h014, 32'h20);
      rd(12'h014, 32'h0);
      usb_ss <= 1'b0;
      $display("network wake test done");
   endtask
   task automatic t_frame();
      wr(12'h028, 32'hc);
      sus(32'h3);
      frm(3'b110, 2'b11);
      wake(8'h2, 8'h1);
      frm(3'b011, 2'b00);
      frm(3'b110, 2'b10);
      rd(12'h024, 32'h400);
      $display("frame wake test done");
   endtask
   // link change wake in mode 1 over a usb2 link
   task automatic t_link();
      phy_int <= 1'b1;
      sus(32'h9);
      wake(8'h3, 8'h1);
      rd(12'h024, 32'h600);
      phy_int <= 1'b0;
      wr(12'h014, 32'h30);
      rd(12'h014, 32'h0);
      $display("link wake test done");
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, go, mac_evt, phy_int, usb_ss} = '0;
      {rx_done, rx_good, rx_filt_pass, rx_pattern, rx_da_match, rx_bcast} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      ce = 1'b1;
      pins = 8'hff;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_pin();
      t_net();
      t_frame();
      t_link();
      test_done();
   end
endmodule // swe_core_tb
`default_nettype wire
